// [rtl/eif_forever_bit_a_if.sv]
// interface between the flag logic and its deferral timer.
// assumes both ends run on the same main clock.
`default_nettype none
interface eif_forever_bit_a_if;
  logic run;
  logic expired;
  modport ctrl (output run, input expired);
  modport timer (input run, output expired);
endinterface : eif_forever_bit_a_if
`default_nettype wire

// [rtl/eif_forever_bit_a_timer.sv]
// deferral timer: counts cycles of continuous run, pulses once at the limit.
// assumes run drops when the transmission ends or aborts.
`default_nettype none
module eif_forever_bit_a_timer
  import eif_pkg::*;
#(
  parameter int LIMIT = FOREVER_BIT_A_CYCLES
)
(
  input wire logic pclk,
  input wire logic presetn,
  eif_forever_bit_a_if.timer dif
);
  logic [16:0] count_reg;
  logic [16:0] count_next;
  logic hit;
  logic expired_reg;

  // restart whenever run drops, so busy spells never add up
  assign hit = dif.run && (count_reg == 17'(LIMIT - 1));
  // count parks one past the last step, so the expiry pulse fires once per busy spell
  assign count_next = !dif.run ? 17'h00000 :
                      (count_reg == 17'(LIMIT) ? count_reg : count_reg + 17'h00001);
  assign dif.expired = expired_reg;

  // counter and one-shot expiry
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      count_reg <= 17'h00000;
      expired_reg <= 1'b0;
    end
    else
    begin
      count_reg <= count_next;
      expired_reg <= hit;
    end
  end

  // expiry only in the cycle after one with run high
  property p_exp;
    @(posedge pclk) disable iff (!presetn)
    $rose(expired_reg) |-> $past(dif.run);
  endproperty
  expiry_cause_a: assert property (p_exp) else $error("expiry without run");
endmodule : eif_forever_bit_a_timer
`default_nettype wire

// [rtl/eif_irq_top.sv]
// ethernet interrupt flag and request logic with its apb register file.
// assumes transmit, receive, dma and phy engines send one-cycle event pulses
// and levels on the main clock.
//
// Decided for this implementation: the register offsets and the APB slave port.
`default_nettype none
module eif_irq_top
  import eif_pkg::*;
#(
  parameter int FOREVER_BIT_A_LIMIT = FOREVER_BIT_A_CYCLES
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic tx_complete_evt,
  input wire logic tx_retry_exceed_evt,
  input wire logic tx_window_coll_evt,
  input wire logic tx_late_coll_evt,
  input wire logic medium_busy,
  input wire logic tx_frame_evt,
  input wire logic [15:0] tx_frame_len,
  input wire logic per_packet_override,
  input wire logic per_packet_huge_enable,
  input wire logic dma_finish_evt,
  input wire logic phy_link_evt,
  input wire logic rx_packet_evt,
  input wire logic rx_wake_evt,
  input wire logic rx_buffer_full,
  output logic tx_request_bit,
  output logic dma_start_bit,
  output logic tx_status_we,
  output logic [12:0] tx_status_addr,
  output logic int_n
);
  logic [7:0] interrupt_enable_reg;
  logic [7:0] main_control_reg;
  logic [7:0] mac_control_reg_four;
  logic [15:0] max_frame_length_regs;
  logic [12:0] tx_buffer_end_ptr;
  logic [7:0] phy_irq_enable_reg;
  logic [7:0] rx_filter_control_reg;
  logic [7:0] rx_packet_count;
  logic tx_error_flag;
  logic tx_done_flag;
  logic dma_done_flag;
  logic rx_error_flag;
  logic phy_link_flag;
  logic tx_abort_status;
  logic late_collision_status;
  logic pready_reg;
  logic pslverr_reg;
  logic [31:0] prdata_reg;
  logic int_n_reg;
  logic tx_status_we_reg;
  logic [12:0] tx_status_addr_reg;

  // apb decode: answer comes in the first access cycle, no wait states
  logic setup;
  logic wr_en;
  logic mapped;
  assign setup = psel && !penable;
  assign wr_en = psel && penable && pwrite && pready_reg;
  assign mapped = (paddr[1:0] == 2'b00) && (paddr <= OFF_RX_FILTER);
  logic wr_ier;
  logic wr_bfc;
  logic wr_ctl;
  logic wr_stat;
  logic wr_mac;
  logic wr_max;
  logic wr_end;
  logic wr_phy_irq_enable_reg;
  logic wr_cnt;
  logic wr_filt;
  logic rd_phy_irq_request_reg;
  assign wr_ier = wr_en && paddr == OFF_IRQ_ENABLE;
  assign wr_bfc = wr_en && paddr == OFF_IRQ_REQUEST;
  assign wr_ctl = wr_en && paddr == OFF_MAIN_CONTROL;
  assign wr_stat = wr_en && paddr == OFF_CHIP_STATUS;
  assign wr_mac = wr_en && paddr == OFF_MAC_CONTROL;
  assign wr_max = wr_en && paddr == OFF_MAX_FRAME;
  assign wr_end = wr_en && paddr == OFF_TX_END;
  assign wr_phy_irq_enable_reg = wr_en && paddr == OFF_PHY_IRQ_ENABLE;
  assign wr_cnt = wr_en && paddr == OFF_RX_COUNT && pwdata[0];
  assign wr_filt = wr_en && paddr == OFF_RX_FILTER;
  // reading the phy request register is what re-arms link detection
  assign rd_phy_irq_request_reg = psel && penable && !pwrite && pready_reg && paddr == OFF_PHY_IRQ_REQUEST;

  // link flag derivation: phy flag gated by both phy enables
  logic phy_en_both;
  logic phy_global_flag;
  logic link_change_flag;
  logic packet_pending_flag;
  assign phy_en_both = phy_irq_enable_reg[BIT_PHY_LINK] && phy_irq_enable_reg[BIT_PHY_GLOBAL_EN];
  assign phy_global_flag = phy_link_flag && phy_en_both;
  assign link_change_flag = phy_global_flag;
  assign packet_pending_flag = rx_packet_count != 8'h00;

  // request register image and summary
  logic [7:0] irq_request;
  logic int_summary;
  assign irq_request = {1'b0, packet_pending_flag, dma_done_flag, link_change_flag,
                        tx_done_flag, 1'b0, tx_error_flag, rx_error_flag};
  assign int_summary = |(irq_request & interrupt_enable_reg & 8'h7F);

  // transmit abort causes; collisions and deferral only matter in half duplex
  logic half_duplex;
  logic tx_active;
  logic oversize;
  logic coll_abort;
  logic forever_bit_a_abort;
  logic tx_abort;
  eif_forever_bit_a_if dif();
  assign half_duplex = !mac_control_reg_four[BIT_FULL_DUPLEX];
  assign tx_active = main_control_reg[BIT_TX_REQUEST];
  assign oversize = tx_frame_evt && (tx_frame_len > max_frame_length_regs) &&
                    !(mac_control_reg_four[BIT_HUGE_FRAME] ||
                      (per_packet_override && per_packet_huge_enable));
  assign coll_abort = half_duplex &&
                      (tx_retry_exceed_evt || tx_window_coll_evt || tx_late_coll_evt);
  assign dif.run = tx_active && medium_busy && half_duplex &&
                   !mac_control_reg_four[BIT_FOREVER_BIT_A_FOREVER];
  assign forever_bit_a_abort = dif.expired && tx_active;
  assign tx_abort = tx_active && (oversize || coll_abort || forever_bit_a_abort);

  // deferral limit is long, so it lives in its own counter
  eif_forever_bit_a_timer #(.LIMIT(FOREVER_BIT_A_LIMIT)) u_forever_bit_a (
    .pclk(pclk),
    .presetn(presetn),
    .dif(dif)
  );

  // control register next value: hardware clears win over host writes
  logic [7:0] ctl_next;
  logic tx_req_fall;
  logic dma_fall;
  assign ctl_next = {wr_ctl ? pwdata[7:6] : main_control_reg[7:6],
                     (wr_ctl ? pwdata[5] : main_control_reg[5]) && !dma_finish_evt,
                     wr_ctl ? pwdata[4] : main_control_reg[4],
                     (wr_ctl ? pwdata[3] : main_control_reg[3]) && !tx_abort &&
                       !(tx_active && tx_complete_evt),
                     wr_ctl ? pwdata[2:0] : main_control_reg[2:0]};
  assign tx_req_fall = main_control_reg[BIT_TX_REQUEST] && !ctl_next[BIT_TX_REQUEST];
  assign dma_fall = main_control_reg[BIT_DMA_START] && !ctl_next[BIT_DMA_START];

  // receive side: accept counts up, full buffer or count 255 discards
  logic rx_in;
  logic rx_drop;
  logic rx_take;
  logic [7:0] cnt_next;
  assign rx_in = rx_packet_evt || (rx_wake_evt && rx_filter_control_reg[BIT_FILTER_WAKE]);
  assign rx_drop = rx_in && (rx_buffer_full || rx_packet_count == PKT_COUNT_MAX);
  assign rx_take = rx_in && !rx_drop;
  assign cnt_next = rx_packet_count + {7'h00, rx_take} -
                    {7'h00, wr_cnt && packet_pending_flag};

  // read mux
  logic [31:0] rd_mux;
  assign rd_mux =
    paddr == OFF_IRQ_ENABLE ? {24'h000000, interrupt_enable_reg} :
    paddr == OFF_IRQ_REQUEST ? {24'h000000, irq_request} :
    paddr == OFF_MAIN_CONTROL ? {24'h000000, main_control_reg} :
    paddr == OFF_CHIP_STATUS ? {24'h000000, int_summary, 2'b00, late_collision_status,
                                2'b00, tx_abort_status, 1'b0} :
    paddr == OFF_MAC_CONTROL ? {24'h000000, mac_control_reg_four} :
    paddr == OFF_MAX_FRAME ? {16'h0000, max_frame_length_regs} :
    paddr == OFF_TX_END ? {19'h00000, tx_buffer_end_ptr} :
    paddr == OFF_PHY_IRQ_ENABLE ? {24'h000000, phy_irq_enable_reg} :
    paddr == OFF_PHY_IRQ_REQUEST ? {27'h0000000, phy_link_flag, 1'b0, phy_global_flag, 2'b00} :
    paddr == OFF_RX_COUNT ? {24'h000000, rx_packet_count} :
    paddr == OFF_RX_FILTER ? {24'h000000, rx_filter_control_reg} : 32'h00000000;

  // apb handshake registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h00000000;
    end
    else
    begin
      pready_reg <= setup;
      pslverr_reg <= setup && !mapped;
      prdata_reg <= (setup && !pwrite) ? rd_mux : 32'h00000000;
    end
  end

  // configuration registers written by software
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      interrupt_enable_reg <= RST_BYTE;
      mac_control_reg_four <= RST_BYTE;
      max_frame_length_regs <= RST_MAX_FRAME;
      tx_buffer_end_ptr <= RST_TX_END;
      phy_irq_enable_reg <= RST_BYTE;
      rx_filter_control_reg <= RST_BYTE;
      main_control_reg <= RST_BYTE;
    end
    else
    begin
      if (wr_ier)
        interrupt_enable_reg <= pwdata[7:0] & 8'hFB;
      if (wr_mac)
        mac_control_reg_four <= pwdata[7:0];
      if (wr_max)
        max_frame_length_regs <= pwdata[15:0];
      if (wr_end)
        tx_buffer_end_ptr <= pwdata[12:0];
      if (wr_phy_irq_enable_reg)
        phy_irq_enable_reg <= pwdata[7:0] & 8'h12;
      if (wr_filt)
        rx_filter_control_reg <= pwdata[7:0];
      main_control_reg <= ctl_next;
    end
  end

  // sticky flags: a set in the same cycle as a clear wins
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tx_error_flag <= 1'b0;
      tx_done_flag <= 1'b0;
      dma_done_flag <= 1'b0;
      rx_error_flag <= 1'b0;
      phy_link_flag <= 1'b0;
      tx_abort_status <= 1'b0;
      late_collision_status <= 1'b0;
      rx_packet_count <= RST_BYTE;
    end
    else
    begin
      tx_error_flag <= tx_abort || (tx_error_flag && !(wr_bfc && pwdata[BIT_TXERR]));
      tx_done_flag <= tx_req_fall || (tx_done_flag && !(wr_bfc && pwdata[BIT_TXDONE]));
      dma_done_flag <= dma_fall || (dma_done_flag && !(wr_bfc && pwdata[BIT_DMA]));
      rx_error_flag <= rx_drop || (rx_error_flag && !(wr_bfc && pwdata[BIT_RXERR]));
      phy_link_flag <= phy_link_evt || (phy_link_flag && !rd_phy_irq_request_reg);
      tx_abort_status <= tx_abort || (tx_abort_status && !(wr_stat && pwdata[BIT_TX_ABORT]));
      late_collision_status <= (tx_active && half_duplex && tx_late_coll_evt) ||
        (late_collision_status && !(wr_stat && pwdata[BIT_LATE_COLL]));
      rx_packet_count <= cnt_next;
    end
  end

  // outputs: pin, status vector store strobe
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      int_n_reg <= 1'b1;
      tx_status_we_reg <= 1'b0;
      tx_status_addr_reg <= RST_TX_END;
    end
    else
    begin
      int_n_reg <= !(int_summary && interrupt_enable_reg[BIT_GLOBAL]);
      tx_status_we_reg <= tx_abort;
      tx_status_addr_reg <= tx_buffer_end_ptr + 13'h0001;
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign tx_request_bit = main_control_reg[BIT_TX_REQUEST];
  assign dma_start_bit = main_control_reg[BIT_DMA_START];
  assign tx_status_we = tx_status_we_reg;
  assign tx_status_addr = tx_status_addr_reg;
  assign int_n = int_n_reg;

  // checks
  oversize_abort_a: assert property (@(posedge pclk) disable iff (!presetn)
    (tx_active && oversize) |=> (tx_error_flag && !tx_request_bit))
    else $error("oversize frame not aborted");
  err_with_done_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(tx_error_flag) |-> tx_done_flag)
    else $error("tx error without tx done");
  req_fall_done_a: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(tx_request_bit) |-> tx_done_flag)
    else $error("tx done missing on request fall");
  flag_sticky_a: assert property (@(posedge pclk) disable iff (!presetn)
    ($past(tx_error_flag) && !$past(wr_bfc)) |-> tx_error_flag)
    else $error("tx error flag dropped without clear");
  pin_low_a: assert property (@(posedge pclk) disable iff (!presetn)
    (int_summary && interrupt_enable_reg[BIT_GLOBAL]) |=> !int_n)
    else $error("interrupt pin not driven low");
  global_off_a: assert property (@(posedge pclk) disable iff (!presetn)
    !interrupt_enable_reg[BIT_GLOBAL] [*2] |-> int_n)
    else $error("pin low with global enable clear");
  link_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
    !phy_en_both |-> !irq_request[BIT_LINK])
    else $error("link flag set without phy enables");
  link_read_a: assert property (@(posedge pclk) disable iff (!presetn)
    (setup && !pwrite && paddr == OFF_IRQ_REQUEST && !phy_en_both) |=> !prdata[BIT_LINK])
    else $error("link flag read without phy enables");
  link_mirror_a: assert property (@(posedge pclk) disable iff (!presetn)
    (phy_link_evt && phy_en_both && !wr_phy_irq_enable_reg) |=> irq_request[BIT_LINK])
    else $error("link flag does not follow phy flag");
  abort_vector_a: assert property (@(posedge pclk) disable iff (!presetn)
    tx_abort |=> tx_status_we && tx_abort_status &&
      tx_status_addr == $past(tx_buffer_end_ptr) + 13'h0001)
    else $error("abort vector store wrong");
  dma_fall_a: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(dma_start_bit) |-> dma_done_flag)
    else $error("dma done missing");
  pending_count_a: assert property (@(posedge pclk) disable iff (!presetn)
    irq_request[BIT_PKT] == (rx_packet_count != 8'h00))
    else $error("packet pending mismatch");
  pending_take_a: assert property (@(posedge pclk) disable iff (!presetn)
    rx_take |=> irq_request[BIT_PKT])
    else $error("accepted packet left pending flag clear");
endmodule : eif_irq_top
`default_nettype wire

// [rtl/eif_pkg.sv]
// constants of the ethernet interrupt flag block: register offsets, bit positions,
// reset values and the deferral time.
// assumes a 20 MHz main clock and an apb master with 32-bit data.
`default_nettype none
package eif_pkg;
  // main clock rate
  localparam int CLK_HZ = 20000000;
  // byte offsets of the registers
  localparam logic [7:0] OFF_IRQ_ENABLE = 8'h00;
  localparam logic [7:0] OFF_IRQ_REQUEST = 8'h04;
  localparam logic [7:0] OFF_MAIN_CONTROL = 8'h08;
  localparam logic [7:0] OFF_CHIP_STATUS = 8'h0C;
  localparam logic [7:0] OFF_MAC_CONTROL = 8'h10;
  localparam logic [7:0] OFF_MAX_FRAME = 8'h14;
  localparam logic [7:0] OFF_TX_END = 8'h18;
  localparam logic [7:0] OFF_PHY_IRQ_ENABLE = 8'h1C;
  localparam logic [7:0] OFF_PHY_IRQ_REQUEST = 8'h20;
  localparam logic [7:0] OFF_RX_COUNT = 8'h24;
  localparam logic [7:0] OFF_RX_FILTER = 8'h28;
  // enable and request bit positions (same layout in both registers)
  localparam int BIT_GLOBAL = 7;
  localparam int BIT_PKT = 6;
  localparam int BIT_DMA = 5;
  localparam int BIT_LINK = 4;
  localparam int BIT_TXDONE = 3;
  localparam int BIT_TXERR = 1;
  localparam int BIT_RXERR = 0;
  // main control bits
  localparam int BIT_DMA_START = 5;
  localparam int BIT_TX_REQUEST = 3;
  // chip status bits
  localparam int BIT_INT_SUMMARY = 7;
  localparam int BIT_LATE_COLL = 4;
  localparam int BIT_TX_ABORT = 1;
  // mac control bits
  localparam int BIT_FULL_DUPLEX = 0;
  localparam int BIT_HUGE_FRAME = 1;
  localparam int BIT_FOREVER_BIT_A_FOREVER = 2;
  // phy interrupt enable and request bits
  localparam int BIT_PHY_LINK = 4;
  localparam int BIT_PHY_GLOBAL_EN = 1;
  localparam int BIT_PHY_GLOBAL_FLAG = 2;
  // rx filter control bits
  localparam int BIT_FILTER_CRC = 7;
  localparam int BIT_FILTER_WAKE = 0;
  // reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_MAX_FRAME = 16'h05EE;
  localparam logic [12:0] RST_TX_END = 13'h0000;
  // clearable bits of the request register
  localparam logic [7:0] IRQ_CLEARABLE = 8'h2B;
  localparam logic [7:0] PKT_COUNT_MAX = 8'hFF;
  // deferral limit in microseconds and its cycle count, rounded down
  localparam real FOREVER_BIT_A_LIMIT_US = 2428.7;
  localparam int FOREVER_BIT_A_CYCLES = int'($floor(FOREVER_BIT_A_LIMIT_US * CLK_HZ / 1.0e6));
endpackage : eif_pkg
`default_nettype wire

// [verification/eif_host_model.sv]
// host side model: apb master of the register port, plus the host's
// servicing habits. assumes one main clock shared with the flag block.
`default_nettype none
module eif_host_model
  import eif_pkg::*;
(
  input wire logic pclk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] last_q;
  logic last_err;
  // bus idle from time zero
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
  end
  // one transfer; answer, read data and error are all taken at the closing rising edge
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // no wait limit here: only the bench timeout ends a hung access
    while (pready !== 1'b1)
      @(posedge pclk);
    last_q = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
  // status causes first, so a later abort is not confused with this one
  task automatic service_abort();
    xfer(1'b1, OFF_CHIP_STATUS, 32'h00000012);
    xfer(1'b1, OFF_IRQ_REQUEST, 32'h0000000A);
  endtask : service_abort
  // a transmit is good only if not cancelled here and no abort status
  task automatic tx_success(input logic cancelled, output logic ok);
    xfer(1'b0, OFF_CHIP_STATUS, 32'h00000000);
    ok = !cancelled && last_q[BIT_TX_ABORT] === 1'b0;
  endtask : tx_success
  // wake arming: filter, drain, enables; tx and rx are never disabled here
  task automatic arm_wake();
    xfer(1'b1, OFF_RX_FILTER, 32'h00000081);
    xfer(1'b1, OFF_RX_COUNT, 32'h00000001);
    xfer(1'b1, OFF_IRQ_ENABLE, 32'h000000C0);
  endtask : arm_wake
endmodule : eif_host_model
`default_nettype wire

// [verification/test_ethernet_interrupt_flag_logic.sv]
// self-checking bench of the ethernet interrupt flag block.
// assumes the host model owns the register port; engine events come from here.
`default_nettype none
module test_ethernet_interrupt_flag_logic
  import eif_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, medium_busy, ovr, huge;
  logic rx_buffer_full, tx_request_bit, dma_start_bit, tx_status_we, int_n, we_snap, ok;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, row;
  logic [15:0] tx_frame_len;
  logic [12:0] tx_status_addr;
  // event pulses: 0 done 1 retry 2 window 3 late 4 frame 5 dma 6 link 7 rx 8 wake
  logic [8:0] ev;
  int error_cnt, cmp_count, cyc;
  string tname;
  // size cases: mac ctl, override, huge, length, error expected
  logic [26:0] tbl [5] = '{27'h0080BDF, 27'h0000BDC, 27'h0100BDE, 27'h0060BDE, 27'h0040BDF};
  eif_irq_top #(.FOREVER_BIT_A_LIMIT(20)) eif_irq_top_i (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .tx_complete_evt(ev[0]),
    .tx_retry_exceed_evt(ev[1]), .tx_window_coll_evt(ev[2]), .tx_late_coll_evt(ev[3]),
    .medium_busy(medium_busy), .tx_frame_evt(ev[4]), .tx_frame_len(tx_frame_len),
    .per_packet_override(ovr), .per_packet_huge_enable(huge), .dma_finish_evt(ev[5]),
    .phy_link_evt(ev[6]), .rx_packet_evt(ev[7]), .rx_wake_evt(ev[8]),
    .rx_buffer_full(rx_buffer_full), .tx_request_bit(tx_request_bit),
    .dma_start_bit(dma_start_bit), .tx_status_we(tx_status_we),
    .tx_status_addr(tx_status_addr), .int_n(int_n));
  eif_host_model eif_host_model_i (.pclk(pclk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));
  // 20 MHz main clock
  initial
  begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  // hang guard, far above the roughly 1500 cycles the tests need
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      error_cnt++;
      $display("wrong value at %0t: run timed out", $time);
      results();
    end
  end
  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : results
  task automatic chk_pin(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("wrong value at %0t in %s: got %h want %h", $time, tname, got, exp);
    end
  endtask : chk_pin
  task automatic chk_rd(input logic [7:0] a, input logic [31:0] exp);
    eif_host_model_i.xfer(1'b0, a, 32'h00000000);
    chk_pin(eif_host_model_i.last_q, exp);
  endtask : chk_rd
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    eif_host_model_i.xfer(1'b1, a, d);
  endtask : wr
  // flags land one edge after the pulse, the pin one edge later
  task automatic settle();
    repeat (2) @(posedge pclk);
    #1;
  endtask : settle
  task automatic pulse(input int i);
    @(posedge pclk);
    ev[i] <= 1'b1;
    @(posedge pclk);
    ev <= '0;
    #1;
    we_snap = tx_status_we;
    settle();
  endtask : pulse
  task automatic do_reset();
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
  endtask : do_reset
  task automatic done_test();
    $display("test %s done", tname);
  endtask : done_test
  // main sequence
  initial
  begin
    presetn = 1'b0;
    ev = '0;
    medium_busy = 1'b0;
    ovr = 1'b0;
    huge = 1'b0;
    rx_buffer_full = 1'b0;
    tx_frame_len = 16'h0040;
    do_reset();
    tname = "reset";
    chk_rd(OFF_MAX_FRAME, 32'h000005EE);
    chk_rd(OFF_IRQ_ENABLE, 32'h00000000);
    chk_pin(int_n, 1'b1);
    eif_host_model_i.xfer(1'b0, 8'h3C, 32'h00000000);
    chk_pin(eif_host_model_i.last_err, 1'b1);
    chk_pin(eif_host_model_i.last_q, 32'h00000000);
    done_test();
    tname = "collision";
    wr(OFF_TX_END, 32'h00000100);
    wr(OFF_IRQ_ENABLE, 32'h00000082);
    for (int i = 1; i < 4; i++)
    begin
      wr(OFF_MAIN_CONTROL, 32'h00000008);
      pulse(i);
      chk_pin({we_snap, tx_request_bit, 17'h0, tx_status_addr}, 32'h80000101);
      chk_pin(int_n, 1'b0);
      chk_rd(OFF_IRQ_REQUEST, 32'h0000000A);
      wr(OFF_IRQ_REQUEST, 32'h00000000);
      chk_rd(OFF_IRQ_REQUEST, 32'h0000000A);
      chk_rd(OFF_CHIP_STATUS, (i == 3) ? 32'h00000092 : 32'h00000082);
      eif_host_model_i.service_abort();
      settle();
      chk_pin(int_n, 1'b1);
    end
    done_test();
    tname = "complete and cancel";
    wr(OFF_MAIN_CONTROL, 32'h00000008);
    pulse(0);
    chk_rd(OFF_IRQ_REQUEST, 32'h00000008);
    eif_host_model_i.tx_success(1'b0, ok);
    chk_pin(ok, 1'b1);
    wr(OFF_IRQ_REQUEST, 32'h00000008);
    wr(OFF_MAIN_CONTROL, 32'h00000008);
    wr(OFF_MAIN_CONTROL, 32'h00000000);
    chk_rd(OFF_IRQ_REQUEST, 32'h00000008);
    wr(OFF_IRQ_REQUEST, 32'h00000008);
    done_test();
    tname = "deferral";
    for (int f = 0; f < 2; f++)
    begin
      wr(OFF_MAC_CONTROL, f ? 32'h00000004 : 32'h00000000);
      wr(OFF_MAIN_CONTROL, 32'h00000008);
      @(posedge pclk);
      medium_busy <= 1'b1;
      repeat (40) @(posedge pclk);
      medium_busy <= 1'b0;
      chk_rd(OFF_IRQ_REQUEST, f ? 32'h00000000 : 32'h0000000A);
      wr(OFF_MAIN_CONTROL, 32'h00000000);
      eif_host_model_i.service_abort();
    end
    done_test();
    tname = "frame size";
    foreach (tbl[k])
    begin
      row = {5'h00, tbl[k]};
      wr(OFF_MAC_CONTROL, {24'h0, row[26:19]});
      wr(OFF_MAIN_CONTROL, 32'h00000008);
      @(posedge pclk);
      ovr <= row[18];
      huge <= row[17];
      tx_frame_len <= row[16:1];
      pulse(4);
      chk_rd(OFF_IRQ_REQUEST, row[0] ? 32'h0000000A : 32'h00000000);
      wr(OFF_MAIN_CONTROL, 32'h00000000);
      eif_host_model_i.service_abort();
    end
    wr(OFF_MAC_CONTROL, 32'h00000001);
    wr(OFF_MAIN_CONTROL, 32'h00000008);
    pulse(3);
    chk_rd(OFF_IRQ_REQUEST, 32'h00000000);
    wr(OFF_MAIN_CONTROL, 32'h00000000);
    wr(OFF_IRQ_REQUEST, 32'h00000008);
    done_test();
    tname = "dma";
    wr(OFF_IRQ_ENABLE, 32'h000000A0);
    wr(OFF_MAIN_CONTROL, 32'h00000020);
    pulse(5);
    chk_pin({dma_start_bit, int_n}, 2'b00);
    wr(OFF_IRQ_ENABLE, 32'h00000020);
    settle();
    chk_pin(int_n, 1'b1);
    wr(OFF_IRQ_REQUEST, 32'h00000020);
    wr(OFF_MAIN_CONTROL, 32'h00000020);
    wr(OFF_MAIN_CONTROL, 32'h00000000);
    chk_rd(OFF_IRQ_REQUEST, 32'h00000020);
    wr(OFF_IRQ_REQUEST, 32'h00000020);
    done_test();
    tname = "link";
    wr(OFF_IRQ_ENABLE, 32'h00000090);
    pulse(6);
    chk_rd(OFF_IRQ_REQUEST, 32'h00000000);
    wr(OFF_PHY_IRQ_ENABLE, 32'h00000012);
    pulse(6);
    chk_pin(int_n, 1'b0);
    wr(OFF_IRQ_REQUEST, 32'h00000010);
    chk_rd(OFF_IRQ_REQUEST, 32'h00000010);
    chk_rd(OFF_PHY_IRQ_REQUEST, 32'h00000014);
    chk_rd(OFF_IRQ_REQUEST, 32'h00000000);
    done_test();
    tname = "packets";
    eif_host_model_i.arm_wake();
    pulse(8);
    chk_pin(int_n, 1'b0);
    chk_rd(OFF_RX_COUNT, 32'h00000001);
    chk_rd(OFF_CHIP_STATUS, 32'h00000080);
    wr(OFF_IRQ_REQUEST, 32'h00000040);
    chk_rd(OFF_IRQ_REQUEST, 32'h00000040);
    wr(OFF_RX_COUNT, 32'h00000001);
    chk_rd(OFF_IRQ_REQUEST, 32'h00000000);
    chk_pin(int_n, 1'b1);
    @(posedge pclk);
    rx_buffer_full <= 1'b1;
    pulse(7);
    rx_buffer_full <= 1'b0;
    chk_rd(OFF_IRQ_REQUEST, 32'h00000001);
    wr(OFF_IRQ_REQUEST, 32'h00000001);
    pulse(7);
    chk_pin(int_n, 1'b0);
    repeat (254) pulse(7);
    pulse(7);
    chk_rd(OFF_RX_COUNT, 32'h000000FF);
    chk_rd(OFF_IRQ_REQUEST, 32'h00000041);
    do_reset();
    chk_rd(OFF_IRQ_REQUEST, 32'h00000000);
    chk_pin(int_n, 1'b1);
    done_test();
    results();
  end
endmodule : test_ethernet_interrupt_flag_logic
`default_nettype wire
